// file: rcso_pkg.sv
package rcso_pkg;

  // Counter bank shape
  localparam int RCSO_NUM_CTR    = 16;
  localparam int RCSO_CTR_W      = 32;
  localparam int RCSO_SEL_HI_POS = 32;
  localparam int RCSO_READ_ERR_BIT = 63;
  localparam int RCSO_USER_W     = 48;

  // Register offsets on the processor address lines
  localparam logic [6:0] RCSO_OFS_STALL_TALLY = 7'h05;
  localparam logic [6:0] RCSO_OFS_DROP_TALLY  = 7'h06;
  localparam logic [6:0] RCSO_OFS_SRC_SELECT  = 7'h08;
  localparam logic [6:0] RCSO_OFS_CLEAR_MASK  = 7'h0a;
  localparam logic [6:0] RCSO_OFS_ENABLE_MASK = 7'h0b;
  localparam logic [6:0] RCSO_OFS_DISABLE_MASK = 7'h0c;

  // Address groups of sixteen (upper three address bits)
  localparam logic [2:0] RCSO_GRP_COUNTER = 3'h2;
  localparam logic [2:0] RCSO_GRP_TRACE   = 3'h6;
  localparam logic [2:0] RCSO_GRP_RSRC    = 3'h7;

  // Counting source encodings
  localparam logic [1:0] RCSO_SRC_SLOW = 2'h0;
  localparam logic [1:0] RCSO_SRC_PIN  = 2'h1;
  localparam logic [1:0] RCSO_SRC_SOFT = 2'h2;
  localparam logic [1:0] RCSO_SRC_NODE = 2'h3;

  // Sample class codes and lengths in bytes
  localparam logic [1:0] RCSO_CLASS_TRACE = 2'h2;
  localparam logic [1:0] RCSO_CLASS_RSRC  = 2'h3;
  localparam logic [6:0] RCSO_TRACE_BYTES = 7'h10;
  localparam logic [6:0] RCSO_RSRC_BYTES  = 7'h50;

  // Reset values
  localparam logic [31:0] RCSO_CTR_RESET   = 32'h0000_0000;
  localparam logic [31:0] RCSO_TALLY_RESET = 32'h0000_0000;
  localparam logic [15:0] RCSO_MASK_RESET  = 16'h0000;
  localparam logic        RCSO_NET_CLOCK_RESET = 1'b0;

  // Byte handed to the network stage
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } rcso_byte_t;

  // Ten-bit network element
  typedef struct packed {
    logic       last;
    logic       parity;
    logic [7:0] data;
  } rcso_net_elem_t;

  typedef enum {BS_IDLE, BS_STALL, BS_ACK} rcso_bus_state_t;

endpackage

// file: rcso_net_out.sv
`timescale 1ns/100ps
module rcso_net_out (
  // Clock and reset
  input  wire logic                i_clock,
  input  wire logic                i_reset,
  // Byte source
  input  rcso_pkg::rcso_byte_t     i_byte,
  input  wire logic                i_valid,
  output logic                     o_taken,
  // Network pins
  input  wire logic                i_fifo_free,
  output logic                     o_net_clock,
  output rcso_pkg::rcso_net_elem_t o_net,
  output logic                     o_load_n
);
  import rcso_pkg::*;

  logic free_s1_q;
  logic free_s2_q;

  function automatic logic odd_parity(input logic [7:0] d);
    return ~(^d);
  endfunction

  // Free pin synchroniser; the lag delays loads and can let one more through after room goes
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      free_s1_q <= 1'b0;
      free_s2_q <= 1'b0;
    end
    else
    begin
      free_s1_q <= i_fifo_free;
      free_s2_q <= free_s1_q;
    end
  end

  // Take a byte only at the falling network edge, with room outside
  assign o_taken = o_net_clock && i_valid && free_s2_q;

  // Divider: network clock at half the processor clock
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      o_net_clock <= RCSO_NET_CLOCK_RESET;
    else
      o_net_clock <= ~o_net_clock;
  end

  // Element and strobe change only as the network clock falls
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_net    <= '0;
      o_load_n <= 1'b1;
    end
    else if (o_net_clock)
    begin
      o_load_n <= ~o_taken;
      if (o_taken)
        o_net <= '{last: i_byte.last, parity: odd_parity(i_byte.data),
                   data: i_byte.data};
    end
  end

  AST_NET_CLOCK_HALF: assert property (@(posedge i_clock) disable iff (i_reset)
    o_net_clock |=> !o_net_clock ##1 o_net_clock)
    else $error("network clock is not half rate");

  AST_LOAD_NEEDS_FREE: assert property (@(posedge i_clock) disable iff (i_reset)
    (!o_load_n && !o_net_clock) |-> $past(free_s2_q))
    else $error("load strobe without free room");

  AST_ODD_PARITY: assert property (@(posedge i_clock) disable iff (i_reset)
    !o_load_n |-> (^{o_net.parity, o_net.data}) == 1'b1)
    else $error("element parity is not odd");

  AST_DATA_AT_FALL: assert property (@(posedge i_clock) disable iff (i_reset)
    $changed(o_net) |-> !o_net_clock)
    else $error("element changed away from falling network edge");

endmodule // rcso_net_out

// file: rcso_top.sv
`timescale 1ns/100ps
module rcso_top (
  // Clock and reset
  input  wire logic                i_clock,
  input  wire logic                i_reset,
  // Processor bus
  input  wire logic [6:0]          i_addr,
  input  wire logic                i_rd_strobe,
  input  wire logic                i_wr_strobe,
  input  wire logic [63:0]         i_data,
  output logic [63:0]              o_data,
  output logic                     o_data_oe_n,
  output logic                     o_ready,
  // Sample content
  input  wire logic [7:0]          i_cpu_line,
  input  wire logic [39:0]         i_timestamp,
  input  wire logic [31:0]         i_source_id,
  // Control levels
  input  wire logic                i_write_wait_enable,
  input  wire logic                i_read_wait_enable,
  // Counting sources
  input  wire logic [15:0]         i_count_pin,
  input  wire logic                i_slow_clock,
  // Collection network
  input  wire logic                i_fifo_free,
  output logic                     o_net_clock,
  output rcso_pkg::rcso_net_elem_t o_net,
  output logic                     o_load_n
);
  import rcso_pkg::*;

  rcso_bus_state_t  state_q;
  logic [6:0]       req_addr_q;
  logic             req_wr_q;
  logic [63:0]      req_wdata_q;
  logic [15:0]      pin_s1_q, pin_s2_q, pin_s3_q;
  logic             slow_s1_q, slow_s2_q, slow_s3_q;
  logic [15:0][31:0] ctr_q;
  logic [15:0][31:0] shadow_q;
  logic [15:0]      enable_q, sel_lo_q, sel_hi_q;
  logic [31:0]      stall_tally_q, drop_tally_q;
  logic [15:0][7:0] slot_q;
  logic [6:0]       len_q, idx_q;
  logic             slot_busy_q, shadow_full_q;
  logic             fifo_ovr_q, shadow_ovr_q;
  logic [6:0]       cur_addr;
  logic             cur_wr;
  logic [63:0]      cur_wdata;
  logic [3:0]       cidx;
  logic             active, is_ctr, is_trace, is_rsrc, rd_busy, trig_busy;
  logic             stall_now, go, wr_go, rd_go, take_sample, drop_sample, capture;
  logic             wait_on, tx_taken, last_byte;
  logic [63:0]      rd_value;
  logic [15:0]      pin_rise, clear_bits, sw_inc, tick;
  logic             slow_rise;
  logic [6:0]       soff;
  rcso_byte_t       tx_byte;

  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    return (v == 32'hffff_ffff) ? v : v + 32'h0000_0001;
  endfunction

  function automatic logic [2:0] cpu_encode(input logic [7:0] lines);
    logic [2:0] n;
    n = 3'h0;
    for (int k = 0; k < 8; k++)
      if (lines[k])
        n = 3'(k);
    return n;
  endfunction

  function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
    return a == ofs;
  endfunction

  // Pin synchronisers; edge detect looks only past the second stage
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      pin_s1_q  <= '0;
      pin_s2_q  <= '0;
      pin_s3_q  <= '0;
      slow_s1_q <= 1'b0;
      slow_s2_q <= 1'b0;
      slow_s3_q <= 1'b0;
    end
    else
    begin
      pin_s1_q  <= i_count_pin;
      pin_s2_q  <= pin_s1_q;
      pin_s3_q  <= pin_s2_q;
      slow_s1_q <= i_slow_clock;
      slow_s2_q <= slow_s1_q;
      slow_s3_q <= slow_s2_q;
    end
  end

  assign pin_rise  = pin_s2_q & ~pin_s3_q;
  assign slow_rise = slow_s2_q & ~slow_s3_q;

  // Request decode; a stalled request replays from its latched copy
  always_comb
  begin
    cur_addr  = (state_q == BS_STALL) ? req_addr_q : i_addr;
    cur_wr    = (state_q == BS_STALL) ? req_wr_q : i_wr_strobe;
    cur_wdata = (state_q == BS_STALL) ? req_wdata_q : i_data;
    active    = ((state_q == BS_IDLE) && (i_rd_strobe || i_wr_strobe))
                || (state_q == BS_STALL);
    cidx      = cur_addr[3:0];
    is_ctr    = cur_addr[6:4] == RCSO_GRP_COUNTER;
    is_trace  = cur_addr[6:4] == RCSO_GRP_TRACE;
    is_rsrc   = cur_addr[6:4] == RCSO_GRP_RSRC;
    rd_busy   = !cur_wr && is_ctr && shadow_full_q;
    trig_busy = cur_wr && ((is_trace && slot_busy_q)
                || (is_rsrc && (slot_busy_q || shadow_full_q)));
    stall_now = active && ((rd_busy && i_read_wait_enable)
                || (trig_busy && i_write_wait_enable));
    go          = active && !stall_now;
    wr_go       = go && cur_wr;
    rd_go       = go && !cur_wr;
    take_sample = wr_go && (is_trace || is_rsrc) && !trig_busy;
    drop_sample = wr_go && trig_busy;
    capture     = (rd_go && is_ctr && !shadow_full_q)
                  || (take_sample && is_rsrc);
    wait_on     = i_write_wait_enable || i_read_wait_enable;
  end

  // Read data; unmapped and write-only offsets read as zero
  always_comb
  begin
    rd_value = 64'h0;
    if (is_ctr)
      rd_value = shadow_full_q ? 64'h8000_0000_0000_0000
                               : {32'h0, ctr_q[cidx]};
    else if (hit(cur_addr, RCSO_OFS_STALL_TALLY))
      rd_value = {32'h0, stall_tally_q};
    else if (hit(cur_addr, RCSO_OFS_DROP_TALLY))
      rd_value = {32'h0, drop_tally_q};
    else if (hit(cur_addr, RCSO_OFS_SRC_SELECT))
      rd_value = {16'h0, sel_hi_q, 16'h0, sel_lo_q};
    else if (hit(cur_addr, RCSO_OFS_ENABLE_MASK))
      rd_value = {48'h0, enable_q};
  end

  // Bus handshake: one-cycle ready; extra cycles only while stalled
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_q     <= BS_IDLE;
      o_ready     <= 1'b0;
      o_data_oe_n <= 1'b1;
      o_data      <= 64'h0;
      req_addr_q  <= 7'h0;
      req_wr_q    <= 1'b0;
      req_wdata_q <= 64'h0;
    end
    else
    begin
      o_ready     <= go;
      o_data_oe_n <= ~rd_go;
      if (rd_go)
        o_data <= rd_value;
      case (state_q)
        BS_IDLE:
          if (go)
            state_q <= BS_ACK;
          else if (stall_now)
          begin
            state_q     <= BS_STALL;
            req_addr_q  <= i_addr;
            req_wr_q    <= i_wr_strobe;
            req_wdata_q <= i_data;
          end
        BS_STALL:
          if (go)
            state_q <= BS_ACK;
        BS_ACK:
          state_q <= BS_IDLE;
        default:
          state_q <= BS_IDLE;
      endcase
    end
  end

  // Control mask decode from bus writes
  always_comb
  begin
    clear_bits = (wr_go && hit(cur_addr, RCSO_OFS_CLEAR_MASK))
                 ? cur_wdata[15:0] : 16'h0;
    sw_inc = 16'h0;
    if (wr_go && is_ctr)
      sw_inc[cidx] = 1'b1;
    for (int i = 0; i < RCSO_NUM_CTR; i++)
    begin
      case ({sel_hi_q[i], sel_lo_q[i]})
        RCSO_SRC_SLOW: tick[i] = slow_rise;
        RCSO_SRC_PIN:  tick[i] = pin_rise[i];
        RCSO_SRC_SOFT: tick[i] = sw_inc[i];
        RCSO_SRC_NODE: tick[i] = 1'b1;
        default:       tick[i] = 1'b0;
      endcase
      tick[i] = tick[i] & enable_q[i];
    end
  end

  // Source select and enable state
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      sel_lo_q <= RCSO_MASK_RESET;
      sel_hi_q <= RCSO_MASK_RESET;
      enable_q <= RCSO_MASK_RESET;
    end
    else if (wr_go)
    begin
      if (hit(cur_addr, RCSO_OFS_SRC_SELECT))
      begin
        sel_lo_q <= cur_wdata[15:0];
        sel_hi_q <= cur_wdata[RCSO_SEL_HI_POS +: 16];
      end
      if (hit(cur_addr, RCSO_OFS_ENABLE_MASK))
        enable_q <= enable_q | cur_wdata[15:0];
      if (hit(cur_addr, RCSO_OFS_DISABLE_MASK))
        enable_q <= enable_q & ~cur_wdata[15:0];
    end
  end

  // Counters: clear beats count, and they stick at all ones
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      ctr_q <= '0;
    else
      for (int i = 0; i < RCSO_NUM_CTR; i++)
        if (clear_bits[i])
          ctr_q[i] <= RCSO_CTR_RESET;
        else if (tick[i])
          ctr_q[i] <= sat_inc(ctr_q[i]);
  end

  // Shadow rank: all counters copied in one edge
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      shadow_q <= '0;
    else if (capture)
      shadow_q <= ctr_q;
  end

  // Lost-sample flags; a loss and a take never share a cycle
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      fifo_ovr_q   <= 1'b0;
      shadow_ovr_q <= 1'b0;
    end
    else if (drop_sample)
    begin
      if (is_rsrc && shadow_full_q)
        shadow_ovr_q <= 1'b1;
      else
        fifo_ovr_q <= 1'b1;
    end
    else if (take_sample)
    begin
      fifo_ovr_q   <= 1'b0;
      shadow_ovr_q <= 1'b0;
    end
  end

  // Tallies wrap by plain 32-bit addition
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      stall_tally_q <= RCSO_TALLY_RESET;
      drop_tally_q  <= RCSO_TALLY_RESET;
    end
    else
    begin
      if (wr_go && hit(cur_addr, RCSO_OFS_STALL_TALLY))
        stall_tally_q <= RCSO_TALLY_RESET;
      else if ((state_q == BS_STALL) && wait_on)
        stall_tally_q <= stall_tally_q + 32'h1;
      if (wr_go && hit(cur_addr, RCSO_OFS_DROP_TALLY))
        drop_tally_q <= RCSO_TALLY_RESET;
      else if (drop_sample && !i_write_wait_enable)
        drop_tally_q <= drop_tally_q + 32'h1;
    end
  end

  // Sample slot and byte walker; shadows free after the last byte
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      slot_q        <= '0;
      len_q         <= RCSO_TRACE_BYTES;
      idx_q         <= 7'h0;
      slot_busy_q   <= 1'b0;
      shadow_full_q <= 1'b0;
    end
    else if (take_sample)
    begin
      slot_q <= {cpu_encode(i_cpu_line), is_rsrc ? RCSO_CLASS_RSRC : RCSO_CLASS_TRACE,
                 fifo_ovr_q, shadow_ovr_q, 1'b0,
                 i_timestamp, i_source_id, cur_wdata[RCSO_USER_W-1:0]};
      len_q       <= is_rsrc ? RCSO_RSRC_BYTES : RCSO_TRACE_BYTES;
      idx_q       <= 7'h0;
      slot_busy_q <= 1'b1;
      if (is_rsrc)
        shadow_full_q <= 1'b1;
    end
    else if (tx_taken)
    begin
      if (last_byte)
      begin
        slot_busy_q   <= 1'b0;
        shadow_full_q <= 1'b0;
      end
      else
        idx_q <= idx_q + 7'h1;
    end
  end

  // Byte selection: header first, fields and counters high byte first
  always_comb
  begin
    soff      = idx_q - RCSO_TRACE_BYTES;
    last_byte = idx_q == (len_q - 7'h1);
    tx_byte.last = last_byte;
    if (idx_q < RCSO_TRACE_BYTES)
      tx_byte.data = slot_q[~idx_q[3:0]];
    else
      tx_byte.data = shadow_q[soff[5:2]][{~soff[1:0], 3'b000} +: 8];
  end

  // Network output stage with its own free-pin synchroniser
  rcso_net_out i_rcso_net_out (
    .i_clock     (i_clock),
    .i_reset     (i_reset),
    .i_byte      (tx_byte),
    .i_valid     (slot_busy_q),
    .o_taken     (tx_taken),
    .i_fifo_free (i_fifo_free),
    .o_net_clock (o_net_clock),
    .o_net       (o_net),
    .o_load_n    (o_load_n)
  );

  AST_READ_BUSY_ERROR: assert property (@(posedge i_clock) disable iff (i_reset)
    (rd_go && is_ctr && shadow_full_q) |=> o_ready && o_data[RCSO_READ_ERR_BIT])
    else $error("busy counter read without error bit");

  AST_READ_FREE_VALUE: assert property (@(posedge i_clock) disable iff (i_reset)
    (rd_go && is_ctr && !shadow_full_q) |=> !o_data[RCSO_READ_ERR_BIT]
    && o_data[31:0] == shadow_q[$past(cidx)])
    else $error("free counter read does not match captured shadow");

  AST_STALL_READ_WAITS: assert property (@(posedge i_clock) disable iff (i_reset)
    (state_q == BS_IDLE && i_rd_strobe && !i_wr_strobe && i_addr[6:4] == RCSO_GRP_COUNTER
     && shadow_full_q && i_read_wait_enable) |=> state_q == BS_STALL && !o_ready)
    else $error("busy read with wait did not stall");

  AST_CLEAR_ZERO: assert property (@(posedge i_clock) disable iff (i_reset)
    clear_bits[3] |=> ctr_q[3] == RCSO_CTR_RESET)
    else $error("cleared counter not zero");

  AST_SATURATE: assert property (@(posedge i_clock) disable iff (i_reset)
    (ctr_q[0] == 32'hffff_ffff && !clear_bits[0]) |=> ctr_q[0] == 32'hffff_ffff)
    else $error("counter wrapped");

  AST_DISABLED_HOLDS: assert property (@(posedge i_clock) disable iff (i_reset)
    (!enable_q[3] && !clear_bits[3]) |=> ctr_q[3] == $past(ctr_q[3]))
    else $error("disabled counter moved");

  AST_STALL_TALLY: assert property (@(posedge i_clock) disable iff (i_reset)
    (state_q == BS_STALL && wait_on) |=> stall_tally_q == $past(stall_tally_q) + 32'h1)
    else $error("stall cycle not tallied");

  AST_DROP_TALLY: assert property (@(posedge i_clock) disable iff (i_reset)
    (drop_sample && !i_write_wait_enable) |=> drop_tally_q == $past(drop_tally_q) + 32'h1
    && (fifo_ovr_q || shadow_ovr_q))
    else $error("dropped sample not tallied");

  AST_SHADOW_HELD: assert property (@(posedge i_clock) disable iff (i_reset)
    (shadow_full_q && !capture) |=> $stable(shadow_q))
    else $error("shadow changed while busy");

  AST_RSRC_LENGTH: assert property (@(posedge i_clock) disable iff (i_reset)
    (take_sample && is_rsrc) |=> len_q == RCSO_RSRC_BYTES && shadow_full_q)
    else $error("resource sample length wrong");

  COV_TRACE_DONE: cover property (@(posedge i_clock) disable iff (i_reset)
    tx_taken && last_byte && len_q == RCSO_TRACE_BYTES);

  COV_RSRC_DONE: cover property (@(posedge i_clock) disable iff (i_reset)
    tx_taken && last_byte && len_q == RCSO_RSRC_BYTES);

  COV_STALLED_READ: cover property (@(posedge i_clock) disable iff (i_reset)
    state_q == BS_STALL ##1 rd_go && is_ctr);

  COV_DROP: cover property (@(posedge i_clock) disable iff (i_reset) drop_sample);

endmodule // rcso_top

// file: rcso_net_sink.sv
`timescale 1ns/100ps
module rcso_net_sink (
  // Network pins
  input  wire logic               i_net_clock,
  input  rcso_pkg::rcso_net_elem_t i_net,
  input  wire logic               i_load_n,
  output logic                    o_fifo_free,
  // Bench control
  input  wire logic               i_stall
);
  import rcso_pkg::*;
  rcso_net_elem_t got [0:255];
  int             count = 0;
  // Room moves on the falling edge, settled long before the rising one
  initial o_fifo_free = 1'b1;
  always @(negedge i_net_clock) o_fifo_free <= !i_stall;
  // Capture the loaded byte at the rising network edge
  always @(posedge i_net_clock)
    if (!i_load_n && count < 256)
    begin
      got[count] <= i_net;
      count      <= count + 1;
    end
endmodule // rcso_net_sink

// file: rcso_top_bench.sv
`timescale 1ns/100ps
module rcso_top_bench;
  import rcso_pkg::*;
  logic           clock = 1'b0, reset = 1'b1, rd = 1'b0, wr = 1'b0;
  logic           wwait = 1'b0, rwait = 1'b0, slow = 1'b0, stall = 1'b0;
  logic           free, net_clock, load_n, oe_n, ready;
  logic [6:0]     addr  = 7'h00;
  logic [63:0]    wdata = 64'h0, dout, rd_v;
  logic [15:0]    pins  = 16'h0000;
  logic [7:0]     cpu   = 8'h04;
  rcso_net_elem_t net;
  int             mismatches = 0, tests_run = 0, base;

  // Processor clock and a slow tick unrelated to it
  always #5 clock = ~clock;
  always #40 slow = ~slow;

  rcso_top i_rcso_top (.i_clock(clock), .i_reset(reset), .i_addr(addr), .i_rd_strobe(rd),
    .i_wr_strobe(wr), .i_data(wdata), .o_data(dout), .o_data_oe_n(oe_n), .o_ready(ready),
    .i_cpu_line(cpu), .i_timestamp(40'h12_3456_789a), .i_source_id(32'hca00_0001),
    .i_write_wait_enable(wwait), .i_read_wait_enable(rwait), .i_count_pin(pins),
    .i_slow_clock(slow), .i_fifo_free(free), .o_net_clock(net_clock), .o_net(net),
    .o_load_n(load_n));
  rcso_net_sink i_rcso_net_sink (.i_net_clock(net_clock), .i_net(net), .i_load_n(load_n),
    .o_fifo_free(free), .i_stall(stall));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One access; request held through the edge at which ready is sampled high
  task automatic bus(input logic w, input logic [6:0] a, input logic [63:0] d);
    int n;
    @(negedge clock);
    addr  = a;
    wdata = d;
    wr    = w;
    rd    = !w;
    n     = 0;
    do
    begin
      @(posedge clock);
      #1;
      n++;
    end
    while (ready !== 1'b1 && n < 3000);
    if (ready !== 1'b1)
    begin
      mismatches++;
      end_sim();
    end
    else
    begin
      rd_v = dout;
      check(oe_n, w);
      @(posedge clock);
      @(negedge clock);
      rd = 1'b0;
      wr = 1'b0;
    end
  endtask

  task automatic wait_bytes(input int n);
    int k;
    for (k = 0; k < 3000 && i_rcso_net_sink.count < n; k++)
      @(posedge clock);
    if (i_rcso_net_sink.count < n)
    begin
      mismatches++;
      end_sim();
    end
  endtask

  // Counter 3 software, 4 node clock, 5 pin edges, 6 slow clock
  task automatic ctr_regs();
    bus(1'b1, 7'h08, 64'h0000_0018_0000_0030);
    bus(1'b0, 7'h08, 64'h0);
    check(rd_v, 64'h0000_0018_0000_0030);
    bus(1'b1, 7'h0b, 64'h78);
    bus(1'b0, 7'h0b, 64'h0);
    check(rd_v, 64'h78);
    // Three rising edges on pin 5, each level held four cycles
    repeat (6)
    begin
      repeat (4) @(negedge clock);
      pins[5] = ~pins[5];
    end
    bus(1'b0, 7'h25, 64'h0);
    check(rd_v, 64'h3);
    bus(1'b0, 7'h26, 64'h0);
    check(rd_v[31:0] != 32'h0, 1'b1);
    bus(1'b1, 7'h23, 64'h0);
    bus(1'b1, 7'h23, 64'h0);
    bus(1'b1, 7'h24, 64'h0);
    bus(1'b0, 7'h23, 64'h0);
    check(rd_v, 64'h2);
    bus(1'b0, 7'h24, 64'h0);
    check(rd_v[31:0] != 32'h0, 1'b1);
    bus(1'b1, 7'h0a, 64'h8);
    bus(1'b0, 7'h23, 64'h0);
    check(rd_v, 64'h0);
    bus(1'b1, 7'h0c, 64'h10);
    bus(1'b1, 7'h23, 64'h0);
    bus(1'b1, 7'h0c, 64'h8);
    bus(1'b1, 7'h23, 64'h0);
    bus(1'b0, 7'h23, 64'h0);
    check(rd_v, 64'h1);
    bus(1'b0, 7'h0a, 64'h0);
    check(rd_v, 64'h0);
  endtask

  task automatic trace_sample();
    int k;
    base = i_rcso_net_sink.count;
    bus(1'b1, 7'h60, 64'h0000_aabb_ccdd_eeff);
    wait_bytes(base + 16);
    check(i_rcso_net_sink.got[base].data, 8'h50);
    check(i_rcso_net_sink.got[base + 1].data, 8'h12);
    check(i_rcso_net_sink.got[base + 6].data, 8'hca);
    check(i_rcso_net_sink.got[base + 10].data, 8'haa);
    check({i_rcso_net_sink.got[base + 14].last, i_rcso_net_sink.got[base + 15].last}, 2'b01);
    for (k = base; k < base + 16; k++)
      check(^{i_rcso_net_sink.got[k].parity, i_rcso_net_sink.got[k].data}, 1'b1);
  endtask

  // Network stalled keeps the shadows busy
  task automatic rsrc_busy();
    @(negedge clock);
    stall = 1'b1;
    cpu   = 8'h80;
    base  = i_rcso_net_sink.count;
    bus(1'b1, 7'h70, 64'h1);
    bus(1'b0, 7'h23, 64'h0);
    check(rd_v[63], 1'b1);
    bus(1'b1, 7'h70, 64'h2);
    bus(1'b0, 7'h06, 64'h0);
    check(rd_v, 64'h1);
    bus(1'b1, 7'h06, 64'h0);
    bus(1'b0, 7'h06, 64'h0);
    check(rd_v, 64'h0);
    rwait = 1'b1;
    fork
      begin
        repeat (100) @(negedge clock);
        stall = 1'b0;
      end
      bus(1'b0, 7'h23, 64'h0);
    join
    check(rd_v, 64'h1);
    bus(1'b0, 7'h05, 64'h0);
    check(rd_v[31:0] != 32'h0, 1'b1);
    wait_bytes(base + 80);
    check(i_rcso_net_sink.got[base].data, 8'hf8);
    check(i_rcso_net_sink.got[base + 31].data, 8'h01);
    check(i_rcso_net_sink.got[base + 39].data, 8'h03);
    check(i_rcso_net_sink.got[base + 79].last, 1'b1);
    // Next taken sample reports the dropped resource sample
    base = i_rcso_net_sink.count;
    bus(1'b1, 7'h60, 64'h0);
    wait_bytes(base + 16);
    check(i_rcso_net_sink.got[base].data, 8'hf2);
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    ctr_regs();
    trace_sample();
    rsrc_busy();
    end_sim();
  end
endmodule // rcso_top_bench
